/* File: logic/voice_sched_pkg.sv */
/*
 * Constants and carriers shared by the transmit voice channel packet scheduler.
 * Assumes the channel structure fields are presented on plain ports by same-clock logic.
 */
// Operation
// - Start-marked service event sets the init flag.
// - Packets only emitted while init reads one.
// - First start event sends nothing, adds write pointer.
// - Zero preload delays sending one packet period.
// - Track oldest unsent byte after initialisation.
// - Size code 000=512 bytes, 001=1024, others reserved.
// - Valid flag zero ignores every service event.
// - Zero suppression pointer disables silence suppression.
// - Suppression pointer counts 32-byte units, bank A.
// - Each frame reads every bearer in order.
// - Bearer count sets extension words read.
// - Sample count is bearers times samples-per-packet.
// - Bearer base counts 512-byte units, bank A.
package voice_sched_pkg;
   localparam logic [2:0] BUF_CODE_256 = 3'h0;
   localparam logic [2:0] BUF_CODE_512 = 3'h1;
   localparam logic [13:0] BUF_BYTES_256 = 14'h0200;
   localparam logic [13:0] BUF_BYTES_512 = 14'h0400;
   localparam int BYTES_PER_SAMPLE = 2;
   localparam int SS_UNIT_SHIFT = 5;
   localparam int BEARER_UNIT_SHIFT = 9;
   localparam logic [15:0] SS_NONE = 16'h0000;
   localparam logic [2:0] RATE_64 = 3'h0;
   localparam logic [2:0] RATE_40 = 3'h1;
   localparam logic [2:0] RATE_32 = 3'h2;
   localparam logic [2:0] RATE_24 = 3'h3;
   localparam logic [2:0] RATE_16 = 3'h4;
   localparam logic [13:0] NEXT_START_RESET = 14'h0000;
   localparam logic [20:0] ADDR_RESET = 21'h000000;

   typedef struct packed {
      logic init;
      logic valid;
      logic [13:0] next_start;
      logic [2:0] buf_size;
      logic [15:0] ss_base;
      logic [7:0] num_bearers;
      logic [7:0] spp_64;
      logic [7:0] spp_40;
      logic [7:0] spp_32;
      logic [7:0] spp_24;
      logic [7:0] spp_16;
   } channel_cfg_type;

   typedef struct packed {
      logic start_marker;
      logic [13:0] write_ptr;
      logic [2:0] rate;
   } service_event_type;

   typedef struct packed {
      logic [20:0] addr;
      logic [7:0] bearer;
      logic last;
   } sample_req_type;
endpackage : voice_sched_pkg

/* File: logic/two_entry_buffer.sv */
/*
 * Two-entry buffer with valid and ready on both sides; outputs come from registers.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module two_entry_buffer #(
   parameter int WIDTH = 30
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic head_valid;
      logic tail_valid;
      logic [WIDTH-1:0] head;
      logic [WIDTH-1:0] tail;
   } buf_state_type;

   buf_state_type r;
   buf_state_type next_r;
   logic push;
   logic pop;

   always_comb begin
      next_r = r;
      pop = r.head_valid && out_ready;
      push = in_valid && !r.tail_valid;
      if (pop) begin
         if (r.tail_valid) begin
            next_r.head = r.tail;
            next_r.tail_valid = 1'b0;
         end else if (push) begin
            next_r.head = in_data;
         end else begin
            next_r.head_valid = 1'b0;
         end
      end else if (push) begin
         if (!r.head_valid) begin
            next_r.head = in_data;
            next_r.head_valid = 1'b1;
         end else begin
            next_r.tail = in_data;
            next_r.tail_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign in_ready = !r.tail_valid;
   assign out_valid = r.head_valid;
   assign out_data = r.head;
endmodule : two_entry_buffer

/* File: logic/tx_voice_channel_packet_scheduler.sv */
/*
 * Transmit scheduler for one voice sample channel added to an outgoing RTP connection.
 * Assumes the channel structure is read and written back by same-clock logic, and that a bearer
 * base address presented for bearer_index is valid in the same cycle.
 */
`timescale 1ns/1ns
module tx_voice_channel_packet_scheduler
   import voice_sched_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire channel_cfg_type cfg,
   input wire logic event_valid,
   input wire service_event_type service_event,
   output logic event_ready,
   output logic [7:0] bearer_index,
   input wire logic [11:0] bearer_base,
   output logic init_write,
   output logic next_start_write,
   output logic [13:0] next_start_value,
   output logic packet_start,
   output logic [15:0] sample_count,
   output logic silence_enable,
   output logic [20:0] silence_address,
   output logic reserved_size,
   output logic req_valid,
   input wire logic req_ready,
   output sample_req_type req_data
);
   typedef enum logic [1:0] {
      IDLE,
      EMIT,
      DONE
   } phase_type;

   typedef struct packed {
      phase_type phase;
      logic [13:0] next_start;
      logic [13:0] mask;
      logic [7:0] spp;
      logic [7:0] num_bearers;
      logic [7:0] frame;
      logic [7:0] bearer;
      logic event_ready;
      logic init_write;
      logic next_start_write;
      logic [13:0] next_start_value;
      logic packet_start;
      logic [15:0] sample_count;
      logic silence_enable;
      logic [20:0] silence_address;
      logic reserved_size;
   } sched_state_type;

   sched_state_type r;
   sched_state_type next_r;
   logic push_valid;
   logic push_ready;
   sample_req_type push_data;

   logic [13:0] size_mask;
   logic size_ok;
   logic [7:0] rate_spp;
   logic [13:0] pending;
   logic [13:0] need;
   logic [13:0] offset;
   logic take_event;
   logic packet_ok;
   logic [13:0] init_start;
   logic [13:0] done_start;
   logic last_bearer;
   logic last_frame;
   logic [20:0] bearer_addr;
   logic [20:0] silence_addr;

   // A reserved size code keeps the small mask but blocks every packet.
   always_comb begin
      size_ok = 1'b1;
      size_mask = BUF_BYTES_256 - 14'h0001;
      case (cfg.buf_size)
         BUF_CODE_256: size_mask = BUF_BYTES_256 - 14'h0001;
         BUF_CODE_512: size_mask = BUF_BYTES_512 - 14'h0001;
         default: size_ok = 1'b0;
      endcase
   end

   // An unknown rate code falls back to the 64 kbps packet length.
   always_comb begin
      case (service_event.rate)
         RATE_64: rate_spp = cfg.spp_64;
         RATE_40: rate_spp = cfg.spp_40;
         RATE_32: rate_spp = cfg.spp_32;
         RATE_24: rate_spp = cfg.spp_24;
         RATE_16: rate_spp = cfg.spp_16;
         default: rate_spp = cfg.spp_64;
      endcase
   end

   // Bytes written by the TDM side but not yet sent, wrapped to the buffer.
   assign pending = (service_event.write_ptr - cfg.next_start) & size_mask;
   assign need = 14'(rate_spp) * 14'(BYTES_PER_SAMPLE);

   // Events on a channel whose valid flag is clear are consumed without effect.
   assign take_event = event_valid && r.event_ready && cfg.valid;

   // A zero preload thus holds the first packet back until a full packet of samples is written.
   assign packet_ok = size_ok && rate_spp != 8'h00 && cfg.num_bearers != 8'h00 && pending >= need;

   // The preload is a distance from the write pointer seen at the first start event.
   assign init_start = (cfg.next_start + service_event.write_ptr) & size_mask;
   // The frames just requested are no longer the oldest unsent bytes.
   assign done_start = (r.next_start + 14'(r.spp) * 14'(BYTES_PER_SAMPLE)) & r.mask;

   assign last_bearer = (r.bearer == r.num_bearers - 8'h01);
   assign last_frame = (r.frame == r.spp - 8'h01);

   // Frame f of every bearer sits at the same wrapped offset in each circular buffer.
   assign offset = (r.next_start + 14'(r.frame) * 14'(BYTES_PER_SAMPLE)) & r.mask;
   assign bearer_addr = {bearer_base, {BEARER_UNIT_SHIFT{1'b0}}};
   assign silence_addr = {cfg.ss_base, {SS_UNIT_SHIFT{1'b0}}};
   assign push_valid = (r.phase == EMIT);
   assign push_data.addr = bearer_addr + {7'h00, offset};
   assign push_data.bearer = r.bearer;
   assign push_data.last = last_frame && last_bearer;

   always_comb begin
      next_r = r;
      next_r.init_write = 1'b0;
      next_r.next_start_write = 1'b0;
      next_r.packet_start = 1'b0;
      case (r.phase)
         IDLE: begin
            if (take_event) begin
               next_r.reserved_size = !size_ok;
               next_r.silence_enable = (cfg.ss_base != SS_NONE);
               next_r.silence_address = silence_addr;
               if (!cfg.init) begin
                  if (service_event.start_marker) begin
                     // First start event: no packet, the preload is shifted by the write pointer.
                     next_r.init_write = 1'b1;
                     next_r.next_start_write = 1'b1;
                     next_r.next_start_value = init_start;
                  end
               end else if (packet_ok) begin
                  next_r.phase = EMIT;
                  next_r.event_ready = 1'b0;
                  next_r.next_start = cfg.next_start;
                  next_r.mask = size_mask;
                  next_r.spp = rate_spp;
                  next_r.num_bearers = cfg.num_bearers;
                  next_r.frame = 8'h00;
                  next_r.bearer = 8'h00;
                  next_r.packet_start = 1'b1;
                  next_r.sample_count = 16'(cfg.num_bearers) * 16'(rate_spp);
               end
            end
         end
         EMIT: begin
            // A refused push keeps frame and bearer, so a stall skips no sample.
            if (push_ready) begin
               if (last_bearer) begin
                  next_r.bearer = 8'h00;
                  if (last_frame) begin
                     next_r.phase = DONE;
                  end else begin
                     next_r.frame = r.frame + 8'h01;
                  end
               end else begin
                  next_r.bearer = r.bearer + 8'h01;
               end
            end
         end
         DONE: begin
            // Oldest unsent byte moves past the packet just issued.
            next_r.next_start_write = 1'b1;
            next_r.next_start_value = done_start;
            next_r.phase = IDLE;
            next_r.event_ready = 1'b1;
         end
         default: begin
            next_r.phase = IDLE;
            next_r.event_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.phase <= IDLE;
         r.event_ready <= 1'b1;
         r.next_start_value <= NEXT_START_RESET;
         r.silence_address <= ADDR_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Requests pass a two-entry buffer, so a stalled reader loses none of them.
   two_entry_buffer #(
      .WIDTH($bits(sample_req_type))
   ) req_buffer (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(req_valid),
      .out_ready(req_ready),
      .out_data(req_data)
   );

   assign event_ready = r.event_ready;
   assign bearer_index = r.bearer;
   assign init_write = r.init_write;
   assign next_start_write = r.next_start_write;
   assign next_start_value = r.next_start_value;
   assign packet_start = r.packet_start;
   assign sample_count = r.sample_count;
   assign silence_enable = r.silence_enable;
   assign silence_address = r.silence_address;
   assign reserved_size = r.reserved_size;
endmodule : tx_voice_channel_packet_scheduler

/* File: verif/bearer_side_model.sv */
/* Far side of the scheduler: bearer base table and a sample sink that stalls.
   Assumes the scheduler's clock and reset. */
`timescale 1ns/1ns
module bearer_side_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] bearer_index,
   output logic [11:0] bearer_base,
   output logic req_ready
);
   logic [1:0] phase;
   // Each bearer buffer sits on its own 512-byte boundary.
   assign bearer_base = 12'h100 + {4'h0, bearer_index};
   // The sink refuses one cycle in three.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) phase <= 2'h0;
      else phase <= #1 (phase == 2'h2) ? 2'h0 : phase + 2'h1;
   end
   assign req_ready = phase != 2'h2;
endmodule : bearer_side_model

/* File: verif/tx_voice_channel_packet_scheduler_assertions.sv */
/* Port checker for the voice channel scheduler.
   Bound to every scheduler instance. */
`timescale 1ns/1ns
module sched_check
   import voice_sched_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire channel_cfg_type cfg,
   input wire logic event_valid,
   input wire service_event_type service_event,
   input wire logic event_ready,
   input wire logic init_write,
   input wire logic [13:0] next_start_value,
   input wire logic packet_start,
   input wire logic silence_enable,
   input wire logic [20:0] silence_address,
   input wire logic reserved_size,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire sample_req_type req_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [13:0] mask;
   assign mask = cfg.buf_size[0] ? 14'h03ff : 14'h01ff;
   sequence take;
      event_valid && event_ready && cfg.valid;
   endsequence
   sequence first_start;
      take ##0 !cfg.init && service_event.start_marker && cfg.buf_size[2:1] == 2'h0;
   endsequence
   a_init_sets: assert property (first_start |=> init_write && next_start_value ==
      (($past(cfg.next_start) + $past(service_event.write_ptr)) & $past(mask))) else $error("init write-back wrong");
   a_ignore_invalid: assert property (event_valid && event_ready && !cfg.valid
      |=> !init_write && !packet_start) else $error("invalid channel acted");
   a_no_init_idle: assert property (take ##0 !cfg.init |=> !packet_start) else $error("packet before init");
   a_silence_map: assert property (take |=> silence_enable == ($past(cfg.ss_base) != 16'h0)
      && silence_address == {$past(cfg.ss_base), 5'h00}) else $error("silence pointer wrong");
   a_size_reserved: assert property (take |=> reserved_size == ($past(cfg.buf_size) > 3'h1))
      else $error("size code decode wrong");
   a_init_pulse: assert property (init_write |=> !init_write) else $error("init write not a pulse");
   a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
      else $error("request lost in stall");
   a_busy_packet: assert property (packet_start |-> !event_ready) else $error("event taken mid packet");
endmodule : sched_check
bind tx_voice_channel_packet_scheduler sched_check i_sched_check (
   .clk(clk),
   .rst_n(rst_n),
   .cfg(cfg),
   .event_valid(event_valid),
   .service_event(service_event),
   .event_ready(event_ready),
   .init_write(init_write),
   .next_start_value(next_start_value),
   .packet_start(packet_start),
   .silence_enable(silence_enable),
   .silence_address(silence_address),
   .reserved_size(reserved_size),
   .req_valid(req_valid),
   .req_ready(req_ready),
   .req_data(req_data)
);

/* File: verif/tx_voice_channel_packet_scheduler_tb.sv */
/* Self-checking bench for the voice channel scheduler.
   Drives events and channel fields; checks write-backs and sample requests. */
`timescale 1ns/1ns
module tx_voice_channel_packet_scheduler_tb;
   import voice_sched_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   // Extra delay frames stay zero and sequence insert stays set, outside these ports.
   channel_cfg_type cfg = '0;
   logic event_valid = 1'b0;
   service_event_type service_event = '0;
   logic event_ready, init_write, next_start_write, packet_start, silence_enable, reserved_size;
   logic req_valid, req_ready, got_init;
   logic [7:0] bearer_index;
   logic [11:0] bearer_base;
   logic [13:0] next_start_value, ns_seen, mask;
   logic [15:0] sample_count;
   logic [20:0] silence_address;
   sample_req_type req_data;
   int num_errors = 0;
   int checks_done = 0;
   initial forever #20 clk = ~clk;
   tx_voice_channel_packet_scheduler i_tx_voice_channel_packet_scheduler (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(cfg),
      .event_valid(event_valid),
      .service_event(service_event),
      .event_ready(event_ready),
      .bearer_index(bearer_index),
      .bearer_base(bearer_base),
      .init_write(init_write),
      .next_start_write(next_start_write),
      .next_start_value(next_start_value),
      .packet_start(packet_start),
      .sample_count(sample_count),
      .silence_enable(silence_enable),
      .silence_address(silence_address),
      .reserved_size(reserved_size),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req_data(req_data)
   );
   bearer_side_model i_bearer_side_model (
      .clk(clk),
      .rst_n(rst_n),
      .bearer_index(bearer_index),
      .bearer_base(bearer_base),
      .req_ready(req_ready)
   );
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   // Offers one event, then gathers the write-backs and sample requests that follow it.
   task automatic serve(input logic sm, input logic [13:0] wp, input logic [2:0] rate, input int n,
      input logic [13:0] ens, input logic ei);
      int k;
      logic [13:0] ns0;
      logic [20:0] a;
      k = 0;
      ns0 = cfg.next_start;
      ns_seen = ns0;
      got_init = 1'b0;
      mask = cfg.buf_size[0] ? 14'h03ff : 14'h01ff;
      @(posedge clk);
      #1 service_event = '{sm, wp, rate};
      event_valid = 1'b1;
      @(posedge clk);
      #1 event_valid = 1'b0;
      repeat (40) begin
         @(negedge clk);
         if (init_write === 1'b1) got_init = 1'b1;
         if (next_start_write === 1'b1) ns_seen = next_start_value;
         if (packet_start === 1'b1) chk("count", sample_count, n);
         if (req_valid === 1'b1 && req_ready === 1'b1) begin
            a = {12'h100 + 12'(k % cfg.num_bearers), 9'h000} + 21'((ns0 + 14'(2 * (k / cfg.num_bearers))) & mask);
            chk("addr", req_data.addr, a);
            chk("last", req_data.last, k == n - 1);
            chk("bearer", req_data.bearer, k % cfg.num_bearers);
            k++;
         end
      end
      chk("requests", k, n);
      chk("next start", ns_seen, ens);
      chk("init", got_init, ei);
      @(posedge clk);
      #1 cfg.next_start = ns_seen;
      if (got_init) cfg.init = 1'b1;
      $display("test done, %0d requests", k);
   endtask : serve
   initial begin
      cfg.num_bearers = 8'h01;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      serve(1'b1, 14'h0005, RATE_64, 0, 14'h0000, 1'b0);
      cfg.valid = 1'b1;
      cfg.next_start = 14'h0003;
      serve(1'b1, 14'h01fe, RATE_64, 0, 14'h0001, 1'b1);
      chk("silence", silence_enable, 1'b0);
      cfg.num_bearers = 8'h02;
      cfg.spp_64 = 8'h02;
      serve(1'b0, 14'h0009, RATE_64, 4, 14'h0005, 1'b0);
      serve(1'b0, 14'h0007, RATE_64, 0, 14'h0005, 1'b0);
      cfg.num_bearers = 8'h01;
      cfg.buf_size = BUF_CODE_512;
      cfg.next_start = 14'h03fe;
      {cfg.spp_64, cfg.spp_40, cfg.spp_32, cfg.spp_24, cfg.spp_16} = 40'h0102030405;
      for (int r = 0; r < 5; r++) begin
         serve(1'b0, (cfg.next_start + 14'h000c) & 14'h03ff, 3'(r), r + 1,
            (cfg.next_start + 14'(2 * r + 2)) & 14'h03ff, 1'b0);
      end
      cfg.init = 1'b0;
      cfg.next_start = 14'h0000;
      serve(1'b1, 14'h0020, RATE_64, 0, 14'h0020, 1'b1);
      serve(1'b0, 14'h0021, RATE_64, 0, 14'h0020, 1'b0);
      serve(1'b0, 14'h0022, RATE_64, 1, 14'h0022, 1'b0);
      cfg.buf_size = 3'h3;
      cfg.ss_base = 16'h0012;
      serve(1'b0, 14'h0100, RATE_64, 0, cfg.next_start, 1'b0);
      chk("reserved", reserved_size, 1'b1);
      chk("silence", silence_enable, 1'b1);
      chk("silence base", silence_address, 21'h000240);
      stop_test();
   end
   initial begin
      #(40 * 3000);
      num_errors++;
      stop_test();
   end
endmodule : tx_voice_channel_packet_scheduler_tb
